// ### include/kr_seq_pkg.sv
// Package with offsets, fields and types of the sequencer control word
package kr_seq_pkg;
    localparam int ADDR_W = 11;
    localparam logic [10:0] OFF_SEQ_CTRL = 11'h4b0;
    localparam logic [10:0] QUAD_LANE_SHIFT = 11'h400;
    localparam logic [10:0] MAP_PHY_LO = 11'h0b0;
    localparam logic [10:0] MAP_PHY_HI = 11'h0ff;
    localparam int BIT_RESTART = 0;
    localparam int BIT_AN_TMR_OFF = 1;
    localparam int BIT_LF_TMR_OFF = 2;
    localparam int BIT_FAIL_ERR = 3;
    localparam int BIT_FORCE_LO = 4;
    localparam int BIT_CAL_EN = 8;
    localparam int BIT_FAIL_ACT = 12;
    localparam logic [31:0] SEQ_CTRL_RESET = 32'h0000_0000;
    localparam logic [3:0] FORCE_NONE = 4'h0;
    localparam logic [3:0] FORCE_GIGE = 4'h1;
    localparam logic [3:0] FORCE_XAUI = 4'h2;
    localparam logic [3:0] FORCE_10GR = 4'h4;
    localparam logic [3:0] FORCE_10GKR = 4'h5;

    typedef enum logic [2:0] {
        MODE_AUTO = 3'b000,
        MODE_GIGE = 3'b001,
        MODE_XAUI = 3'b010,
        MODE_10GR = 3'b011,
        MODE_10GKR = 3'b100
    } protocol_mode_e;

    typedef struct packed {
        logic negotiation_timer_off;
        logic link_fail_timer_off;
        logic training_fail_on_errors;
        logic [3:0] protocol_force_select;
        logic calibration_enable;
        logic training_failure_action;
    } seq_fields_s;

    typedef struct packed {
        logic restart_pulse;
        logic calibration_run;
        protocol_mode_e active_mode;
        logic negotiation_timer_run;
        logic link_fail_timer_run;
        logic training_judge_errors;
        logic failure_to_data_mode;
    } seq_ctrl_out_s;

    typedef struct packed {
        seq_fields_s fields;
        logic restart;
        protocol_mode_e mode;
        logic cal_latched;
        logic [31:0] rdata;
        logic rvalid;
    } seq_state_s;
endpackage

// ### core/kr_sequencer_control.sv
// Sequencer control word register bank with management slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: Restart write resets sequencer, starts reconfiguration
// RQ2: Bit 1 set stops negotiation timer
// RQ3: Bit 2 set stops link-fail timer
// RQ4: Bit 3 fails training on nonzero errors
// RQ5: Bits 7:4 decode the forced protocol
// RQ6: Force value applies only at restart
// RQ7: Bit 8 adds calibration to reconfiguration
// RQ8: Bit 12 picks data mode on failure
// RQ9: Four-lane map offsets sit 0x400 higher
// RQ10: Fields reset to zero
// RQ11: Software avoids reserved addresses
// RQ12: One flat word-addressed slave port
// RQ13: Bits 11:9 reserved, no function
// RQ14: Restart yields one-cycle pulse, reads zero
module kr_sequencer_control
#(
    parameter bit FOUR_LANE = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [kr_seq_pkg::ADDR_W-1:0] mgmt_address,
    input wire logic mgmt_read,
    input wire logic mgmt_write,
    input wire logic [31:0] mgmt_writedata,
    output logic [31:0] mgmt_readdata,
    output logic mgmt_readdatavalid,
    output logic mgmt_waitrequest,
    output kr_seq_pkg::seq_ctrl_out_s seq_ctrl
);
    import kr_seq_pkg::*;

    // ************************************************
    // Address translation
    // ************************************************
    function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] r;
        r = a;
        if (FOUR_LANE && a >= MAP_PHY_LO && a <= MAP_PHY_HI)
        begin
            r = ADDR_W'(a + QUAD_LANE_SHIFT); // RQ9
        end
        return r;
    endfunction

    function automatic protocol_mode_e decode_force(input logic [3:0] f);
        protocol_mode_e m;
        m = MODE_AUTO;
        unique case (f) // RQ5
            FORCE_GIGE: m = MODE_GIGE;
            FORCE_XAUI: m = MODE_XAUI;
            FORCE_10GR: m = MODE_10GR;
            FORCE_10GKR: m = MODE_10GKR;
            default: m = MODE_AUTO;
        endcase
        return m;
    endfunction

    seq_state_s state_reg;
    seq_state_s state_next;
    logic hit;

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        state_next = state_reg;
        hit = (map_addr(mgmt_address) == OFF_SEQ_CTRL); // RQ12
        state_next.restart = 1'b0; // RQ14
        state_next.rvalid = mgmt_read;
        state_next.rdata = 32'h0000_0000;
        if (mgmt_read && hit)
        begin
            state_next.rdata[BIT_RESTART] = 1'b0; // RQ14
            state_next.rdata[BIT_AN_TMR_OFF] = state_reg.fields.negotiation_timer_off;
            state_next.rdata[BIT_LF_TMR_OFF] = state_reg.fields.link_fail_timer_off;
            state_next.rdata[BIT_FAIL_ERR] = state_reg.fields.training_fail_on_errors;
            state_next.rdata[BIT_FORCE_LO +: 4] = state_reg.fields.protocol_force_select;
            state_next.rdata[BIT_CAL_EN] = state_reg.fields.calibration_enable;
            state_next.rdata[BIT_FAIL_ACT] = state_reg.fields.training_failure_action; // RQ8
        end
        if (mgmt_write && hit)
        begin
            state_next.fields.negotiation_timer_off = mgmt_writedata[BIT_AN_TMR_OFF]; // RQ2
            state_next.fields.link_fail_timer_off = mgmt_writedata[BIT_LF_TMR_OFF]; // RQ3
            state_next.fields.training_fail_on_errors = mgmt_writedata[BIT_FAIL_ERR]; // RQ4
            state_next.fields.protocol_force_select = mgmt_writedata[BIT_FORCE_LO +: 4];
            state_next.fields.calibration_enable = mgmt_writedata[BIT_CAL_EN]; // RQ7
            state_next.fields.training_failure_action = mgmt_writedata[BIT_FAIL_ACT]; // RQ8
            if (mgmt_writedata[BIT_RESTART])
            begin
                state_next.restart = 1'b1; // RQ1
                state_next.mode = decode_force(mgmt_writedata[BIT_FORCE_LO +: 4]); // RQ6
                state_next.cal_latched = mgmt_writedata[BIT_CAL_EN]; // RQ7
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= '0; // RQ10
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign mgmt_readdata = state_reg.rdata;
    assign mgmt_readdatavalid = state_reg.rvalid;
    assign mgmt_waitrequest = 1'b0;
    assign seq_ctrl.restart_pulse = state_reg.restart; // RQ1
    assign seq_ctrl.calibration_run = state_reg.restart & state_reg.cal_latched; // RQ7
    assign seq_ctrl.active_mode = state_reg.mode; // RQ6
    assign seq_ctrl.negotiation_timer_run = ~state_reg.fields.negotiation_timer_off; // RQ2
    assign seq_ctrl.link_fail_timer_run = ~state_reg.fields.link_fail_timer_off; // RQ3
    assign seq_ctrl.training_judge_errors = state_reg.fields.training_fail_on_errors; // RQ4
    assign seq_ctrl.failure_to_data_mode = state_reg.fields.training_failure_action; // RQ8
endmodule

`default_nettype wire

// ### verif/seq_ctrl_sva.sv
// Checker for the sequencer control word ports
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_chk
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [10:0] mgmt_address,
    input wire logic mgmt_read,
    input wire logic mgmt_write,
    input wire logic [31:0] mgmt_writedata,
    input wire logic [31:0] mgmt_readdata,
    input wire logic mgmt_readdatavalid,
    input wire logic mgmt_waitrequest,
    input wire kr_seq_pkg::seq_ctrl_out_s seq_ctrl
);
    wire hit = mgmt_write && (mgmt_address == 11'h4b0 || mgmt_address == 11'h0b0);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_go;
        hit && mgmt_writedata[0];
    endsequence
    sequence s_quiet;
        !(hit && mgmt_writedata[0]);
    endsequence
    a_restart_pulse: assert property (s_go |=> seq_ctrl.restart_pulse) else $error("restart pulse missing");
    a_pulse_drop: assert property (s_go ##1 s_quiet |=> !seq_ctrl.restart_pulse) else $error("pulse too long");
    a_no_stall: assert property (!mgmt_waitrequest) else $error("slave stalled");
    a_read_reserved: assert property (mgmt_readdatavalid |-> mgmt_readdata[11:9] == 3'h0 && !mgmt_readdata[0])
        else $error("reserved bits read nonzero");
    a_miss_zero: assert property (mgmt_read && mgmt_address != 11'h4b0 && mgmt_address != 11'h0b0
        |=> mgmt_readdata == 32'h0) else $error("miss read nonzero");
    a_pulse_cause: assert property (seq_ctrl.restart_pulse |-> $past(hit && mgmt_writedata[0])) else $error("stray pulse");
    a_cal_pulse: assert property (seq_ctrl.calibration_run |-> seq_ctrl.restart_pulse && $past(mgmt_writedata[8])) else $error("cal");
    a_mode_hold: assert property (!$past(hit && mgmt_writedata[0]) |-> $stable(seq_ctrl.active_mode)) else $error("mode moved");
    a_an_timer: assert property (hit |=> seq_ctrl.negotiation_timer_run == !$past(mgmt_writedata[1])) else $error("an timer");
    a_lf_timer: assert property (hit |=> seq_ctrl.link_fail_timer_run == !$past(mgmt_writedata[2])) else $error("lf timer");
    a_fail_bits: assert property (hit |=> {seq_ctrl.training_judge_errors, seq_ctrl.failure_to_data_mode}
        == {$past(mgmt_writedata[3]), $past(mgmt_writedata[12])}) else $error("fail bits");
    a_read_valid: assert property (mgmt_read |=> mgmt_readdatavalid) else $error("no read valid");
endmodule
bind kr_sequencer_control seq_ctrl_chk seq_ctrl_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n), .mgmt_address(mgmt_address),
    .mgmt_read(mgmt_read), .mgmt_write(mgmt_write), .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
    .mgmt_readdatavalid(mgmt_readdatavalid), .mgmt_waitrequest(mgmt_waitrequest), .seq_ctrl(seq_ctrl));
`default_nettype wire

// ### verif/kr_sequencer_control_tb_top.sv
// Testbench for the sequencer control word
`timescale 1ns/1ps
`default_nettype none
module kr_sequencer_control_tb_top;
    import kr_seq_pkg::*;
    logic clk_sys = 1'b0, reset_n = 1'b0, mgmt_read = 1'b0, mgmt_write = 1'b0, mgmt_readdatavalid, mgmt_waitrequest;
    logic [10:0] mgmt_address = 11'h0;
    logic [31:0] mgmt_writedata = 32'h0, mgmt_readdata, sh = 32'h0, d, e;
    logic [3:0] p;
    seq_ctrl_out_s seq_ctrl;
    logic [31:0] qr[$];
    logic [3:0] qp[$];
    int err_count = 0, n_checks = 0, cyc = 0;
    kr_sequencer_control kr_sequencer_control_inst (.clk_sys(clk_sys), .reset_n(reset_n), .mgmt_address(mgmt_address),
        .mgmt_read(mgmt_read), .mgmt_write(mgmt_write), .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
        .mgmt_readdatavalid(mgmt_readdatavalid), .mgmt_waitrequest(mgmt_waitrequest), .seq_ctrl(seq_ctrl));
    initial forever #20 clk_sys = ~clk_sys;
    function automatic protocol_mode_e mode_of(input logic [3:0] c);
        case (c)
            4'h1: return MODE_GIGE;
            4'h2: return MODE_XAUI;
            4'h4: return MODE_10GR;
            4'h5: return MODE_10GKR;
            default: return MODE_AUTO;
        endcase
    endfunction
    task automatic wr(input logic [10:0] a, input logic [31:0] v);
        {mgmt_address, mgmt_writedata, mgmt_write} <= {a, v, 1'b1};
        @(posedge clk_sys);
        mgmt_write <= 1'b0;
        sh = (a == 11'h4b0 || a == 11'h0b0) ? v & 32'h11fe : sh;
        if (v[0] && (a == 11'h4b0 || a == 11'h0b0))
            qp.push_back({v[8], mode_of(v[7:4])});
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [10:0] a);
        qr.push_back((a == 11'h4b0 || a == 11'h0b0) ? sh : 32'h0);
        {mgmt_address, mgmt_read} <= {a, 1'b1};
        @(posedge clk_sys);
        mgmt_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            wrap_up();
        end
        if (mgmt_readdatavalid === 1'b1)
        begin
            e = (qr.size() != 0) ? qr.pop_front() : 32'hx;
            n_checks++;
            if (mgmt_readdata !== e)
            begin
                err_count++;
                $display("Error readdata exp %h got %h", e, mgmt_readdata);
            end
        end
        if (seq_ctrl.restart_pulse === 1'b1)
        begin
            p = (qp.size() != 0) ? qp.pop_front() : 4'hx;
            n_checks++;
            if ({seq_ctrl.calibration_run, seq_ctrl.active_mode} !== p)
            begin
                err_count++;
                $display("Error mode exp %h got %h", p, {seq_ctrl.calibration_run, seq_ctrl.active_mode});
            end
        end
    end
    initial
    begin
        void'($urandom(32'h6b5c));
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(11'h4b0);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(11'h4b0, {23'h0, i[0], i[3:0], 4'h0});
            rd(11'h0b0);
            wr(11'h0b0, {23'h0, i[1], i[3:0], 4'h1});
        end
        $display("test force done");
        repeat (20)
        begin
            d = $urandom;
            wr(d[5] ? 11'h4b0 : 11'h0b0, d);
            rd(11'h4b0);
        end
        rd(11'h123);
        $display("test random done");
        reset_n <= 1'b0;
        sh = 32'h0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(11'h4b0);
        rd(11'h0b0);
        $display("test mid reset done");
        repeat (2) @(posedge clk_sys);
        if (qr.size() != 0 || qp.size() != 0)
            err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
